// ===== hw/wsc_regs.vh
/*
 * Register offsets, field positions, reset values and timing figures
 * of the wake / standby input control block.
 * Assumes a 40 MHz pclk and word-aligned APB byte addresses.
 */
`ifndef WSC_REGS_VH
`define WSC_REGS_VH

// register byte offsets
`define WSC_ADDR_CTRL 8'h00
`define WSC_ADDR_STATUS 8'h04
`define WSC_ADDR_MASK 8'h08
`define WSC_ADDR_STATE 8'h0C

// control register fields
`define WSC_CTRL_EDGE 0
`define WSC_CTRL_DBNC_LO 1
`define WSC_CTRL_DBNC_HI 2
`define WSC_CTRL_STBY_INV 3
`define WSC_CTRL_OFF_SLEEP 4
`define WSC_CTRL_W 5
// edge-sensitive, debounce code 01, active-high standby, turn-off to OFF
`define WSC_CTRL_RST 5'h03

// status / mask fields (status sticky, write one to clear; mask plain read/write)
`define WSC_ST_WAKE 0
`define WSC_ST_TURN_ON 1
`define WSC_ST_TURN_OFF 2
`define WSC_ST_W 3
`define WSC_MASK_RST 3'h0

// debounce select codes
`define WSC_DBNC_NONE 2'h0
`define WSC_DBNC_SHORT 2'h1
`define WSC_DBNC_MID 2'h2
`define WSC_DBNC_LONG 2'h3

// timing in pclk cycles at 40 MHz, sized to the counter width so nothing is cut
`define WSC_CLK_MHZ 40
`define WSC_CNT_W 28
`define WSC_T_SHORT_CYC 28'h1312D0 // 31.25 ms
`define WSC_T_MID_CYC 28'h4C4B40 // 125 ms
`define WSC_T_LONG_CYC 28'h1C9C380 // 750 ms
`define WSC_T_OFF_CYC 28'h9896800 // 4.0 s long press

`endif

// ===== hw/wsc_hold_timer.v
/*
 * Hold timer: counts pclk cycles since the sampled input last changed.
 * Assumes its input is already synchronised to pclk.
 */
`timescale 1ns/100ps
module wsc_hold_timer #(
    parameter CW = 28,
    parameter IDLE_LEVEL = 1'b1
) (
    input wire pclk,
    input wire presetn,
    input wire level_in,
    output reg level,
    output reg [CW-1:0] hold_cnt,
    output reg moved
);

    wire changed = level_in != level;

    ////////////////////////////////////////////////////////////////////////
    // restart on every change, saturate so a held level never wraps
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= IDLE_LEVEL;
            hold_cnt <= {CW{1'b0}};
            moved <= 1'b0;
        end else if (changed) begin
            level <= level_in;
            hold_cnt <= {CW{1'b0}};
            moved <= 1'b1;
        end else if (hold_cnt != {CW{1'b1}}) begin
            hold_cnt <= hold_cnt + {{(CW-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ===== hw/wsc_wake_standby.v
/*
 * Wake / standby input control: turn-on and turn-off detection from the
 * wake pin, debounced wake interrupts, standby pin with selectable
 * polarity, a small OFF/ON/Sleep mode tracker and an APB register slave.
 * Assumes wake, standby and supply-good pins are asynchronous to pclk;
 * the regulators themselves and their sequencing sit outside.
 */
// The register offsets and the APB register port were left to the implementer.
// What this block does
// - level mode: wake pin high with supply good turns the part on and sets the wake flag and sense bit.
// - edge mode: a falling wake edge with supply good turns the part on and sets the wake flag; the sense bit then reads low.
// - a turn-on event moves the part from OFF or Sleep into ON.
// - leaving Sleep for ON keeps already enabled regulators on instead of restarting the sequence.
// - in edge mode with debounce codes 01 to 11 the wake input is debounced so very short presses do not turn the part on.
// - the wake interrupt is raised on both the falling and the rising wake edge.
// - by default both edge interrupts are debounced by 31.25 ms.
// - the debounce select gives turn-on debounce 0, 31.25, 125 or 750 ms for codes 00 to 11.
// - falling interrupt debounce is 31.25, 31.25, 125, 750 ms by code; rising is always 31.25 ms.
// - the wake flag stays set until software clears it or the part passes through OFF.
// - the wake sense bit is undebounced and follows the wake pin.
// - standby is entered while the standby input is asserted and left when it is released.
// - standby input polarity is chosen by the standby invert bit.
// - edge mode: wake held low for 4.0 s or more turns the part off or into Sleep.
// - level mode: a low wake pin turns the part off or into Sleep.
`timescale 1ns/100ps
`include "wsc_regs.vh"
module wsc_wake_standby #(
    parameter [`WSC_CNT_W-1:0] T_SHORT_CYC = `WSC_T_SHORT_CYC,
    parameter [`WSC_CNT_W-1:0] T_MID_CYC = `WSC_T_MID_CYC,
    parameter [`WSC_CNT_W-1:0] T_LONG_CYC = `WSC_T_LONG_CYC,
    parameter [`WSC_CNT_W-1:0] T_OFF_CYC = `WSC_T_OFF_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire wake_pin,
    input wire standby_pin,
    input wire supply_above_threshold,
    output reg irq,
    output reg mode_on,
    output reg mode_sleep,
    output reg standby_active,
    output reg start_sequence,
    output reg resume_from_sleep
);

    localparam CW = `WSC_CNT_W;
    localparam [2:0] ST_OFF = 3'h1;
    localparam [2:0] ST_ON = 3'h2;
    localparam [2:0] ST_SLEEP = 3'h4;

    reg [1:0] wake_sync;
    reg [1:0] stby_sync;
    reg [1:0] uv_sync;
    reg [`WSC_CTRL_W-1:0] ctrl;
    reg [`WSC_ST_W-1:0] status;
    reg [`WSC_ST_W-1:0] mask;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [CW-1:0] turn_on_thr;
    reg [CW-1:0] fall_thr;
    reg [31:0] rd_word;
    reg rd_hit;

    wire wake_lvl;
    wire [CW-1:0] hold_cnt;
    wire moved;

    wire edge_mode = ctrl[`WSC_CTRL_EDGE];
    wire [1:0] dbnc_sel = ctrl[`WSC_CTRL_DBNC_HI:`WSC_CTRL_DBNC_LO];
    wire supply_ok = uv_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; wake idles high, standby and supply idle low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_sync <= 2'h3;
            stby_sync <= 2'h0;
            uv_sync <= 2'h0;
        end else begin
            wake_sync <= {wake_sync[0], wake_pin};
            stby_sync <= {stby_sync[0], standby_pin};
            uv_sync <= {uv_sync[0], supply_above_threshold};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time since the synchronised wake level last changed
    wsc_hold_timer #(
        .CW(CW),
        .IDLE_LEVEL(1'b1)
    ) u_hold (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(wake_sync[1]),
        .level(wake_lvl),
        .hold_cnt(hold_cnt),
        .moved(moved)
    );

    ////////////////////////////////////////////////////////////////////////
    // debounce thresholds from the select code
    always @* begin
        case (dbnc_sel)
            `WSC_DBNC_NONE: begin
                turn_on_thr = {CW{1'b0}};
                fall_thr = T_SHORT_CYC;
            end
            `WSC_DBNC_SHORT: begin
                turn_on_thr = T_SHORT_CYC;
                fall_thr = T_SHORT_CYC;
            end
            `WSC_DBNC_MID: begin
                turn_on_thr = T_MID_CYC;
                fall_thr = T_MID_CYC;
            end
            default: begin
                turn_on_thr = T_LONG_CYC;
                fall_thr = T_LONG_CYC;
            end
        endcase
    end

    // a hold count hits each threshold at most once per steady period,
    // so every threshold compare below is a single-cycle pulse; level-mode turn_on and turn_off are levels
    wire fall_irq = moved && !wake_lvl && hold_cnt == fall_thr;
    wire rise_irq = moved && wake_lvl && hold_cnt == T_SHORT_CYC;
    wire edge_on = moved && !wake_lvl && hold_cnt == turn_on_thr;
    wire edge_off = moved && !wake_lvl && hold_cnt == T_OFF_CYC;
    wire turn_on = supply_ok && (edge_mode ? edge_on : wake_lvl);
    wire turn_off = edge_mode ? edge_off : !wake_lvl;
    wire on_evt = turn_on && state != ST_ON;
    wire off_evt = turn_off && state == ST_ON;

    ////////////////////////////////////////////////////////////////////////
    // mode tracker: OFF and Sleep both wake into ON
    always @* begin
        case (state)
            ST_OFF: begin
                next_state = turn_on ? ST_ON : ST_OFF;
            end
            ST_SLEEP: begin
                next_state = turn_on ? ST_ON : ST_SLEEP;
            end
            ST_ON: begin
                if (turn_off)
                    next_state = ctrl[`WSC_CTRL_OFF_SLEEP] ? ST_SLEEP : ST_OFF;
                else
                    next_state = ST_ON;
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
            mode_on <= 1'b0;
            mode_sleep <= 1'b0;
            start_sequence <= 1'b0;
            resume_from_sleep <= 1'b0;
        end else begin
            state <= next_state;
            mode_on <= next_state == ST_ON;
            mode_sleep <= next_state == ST_SLEEP;
            // only a cold start replays the sequence; Sleep exit keeps rails up
            start_sequence <= state == ST_OFF && next_state == ST_ON;
            resume_from_sleep <= state == ST_SLEEP && next_state == ST_ON;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // standby follows the pin through the polarity select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            standby_active <= 1'b0;
        else
            standby_active <= stby_sync[1] ^ ctrl[`WSC_CTRL_STBY_INV];
    end

    ////////////////////////////////////////////////////////////////////////
    // apb: one wait state, so prdata and pready both come from flops
    wire acc_end = psel && penable && pready;
    wire wr_en = acc_end && pwrite;
    wire [`WSC_ST_W-1:0] w1c = (wr_en && paddr == `WSC_ADDR_STATUS) ? pwdata[`WSC_ST_W-1:0] : {`WSC_ST_W{1'b0}};

    always @* begin
        rd_hit = 1'b1;
        rd_word = 32'h00000000;
        case (paddr)
            `WSC_ADDR_CTRL: begin
                rd_word[`WSC_CTRL_W-1:0] = ctrl;
            end
            `WSC_ADDR_STATUS: begin
                rd_word[`WSC_ST_W-1:0] = status;
            end
            `WSC_ADDR_MASK: begin
                rd_word[`WSC_ST_W-1:0] = mask;
            end
            `WSC_ADDR_STATE: begin
                rd_word[0] = wake_sync[1];
                rd_word[1] = standby_active;
                rd_word[4:2] = state;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !rd_hit;
            prdata <= pwrite ? 32'h00000000 : rd_word;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `WSC_CTRL_RST;
            mask <= `WSC_MASK_RST;
        end else if (wr_en && paddr == `WSC_ADDR_CTRL) begin
            ctrl <= pwdata[`WSC_CTRL_W-1:0];
        end else if (wr_en && paddr == `WSC_ADDR_MASK) begin
            mask <= pwdata[`WSC_ST_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status: set beats any clear in the same cycle
    wire [`WSC_ST_W-1:0] st_set = {off_evt, on_evt, fall_irq | rise_irq | on_evt};
    wire [`WSC_ST_W-1:0] st_hwclr = {{(`WSC_ST_W-1){1'b0}}, state == ST_OFF};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= {`WSC_ST_W{1'b0}};
            irq <= 1'b0;
        end else begin
            status <= st_set | (status & ~w1c & ~st_hwclr);
            irq <= |((st_set | (status & ~w1c & ~st_hwclr)) & mask);
        end
    end

endmodule

// ===== verification/wsc_monitor.sv
/* port checker for the wake / standby block.
   assumes one pclk domain and a bind onto the top module */
`timescale 1ns/100ps
module wsc_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire mode_on,
    input wire mode_sleep,
    input wire start_sequence,
    input wire resume_from_sleep
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus answer shape
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    // mode moves and their pulses
    a_start_from_off: assert property (start_sequence |-> mode_on && !$past(mode_on) && !$past(mode_sleep))
        else $error("start pulse not from off");
    a_resume_from_sleep: assert property (resume_from_sleep |-> mode_on && $past(mode_sleep))
        else $error("resume pulse not from sleep");
    a_start_one_shot: assert property (start_sequence |=> !start_sequence && !resume_from_sleep)
        else $error("start pulse too long");
    a_mode_exclusive: assert property (!(mode_on && mode_sleep)) else $error("on and sleep together");
    a_on_has_cause: assert property ($rose(mode_on) |-> start_sequence || resume_from_sleep)
        else $error("on without pulse");
endmodule
////////
bind wsc_wake_standby wsc_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .mode_on(mode_on), .mode_sleep(mode_sleep),
    .start_sequence(start_sequence), .resume_from_sleep(resume_from_sleep));

// ===== verification/wsc_pin_model.sv
/* push-button and host pin model for the wake block.
   assumes its tasks are called from the pclk domain */
`timescale 1ns/100ps
module wsc_pin_model (
    input wire pclk,
    output reg wake_pin,
    output reg standby_pin,
    output reg supply_above_threshold
);
    // button released, pulled high; supply good
    initial begin
        wake_pin = 1'b1;
        standby_pin = 1'b0;
        supply_above_threshold = 1'b1;
    end
    // pins change just after a rising edge
    task set_pins(input logic w, input logic s, input logic v);
        @(posedge pclk);
        wake_pin <= w;
        standby_pin <= s;
        supply_above_threshold <= v;
    endtask
    // bouncing contact: low, high, low, high, len cycles each
    task bounce(input int len);
        int i;
        for (i = 0; i < 4; i++) begin
            @(posedge pclk);
            wake_pin <= i[0];
            repeat (len - 1) @(posedge pclk);
        end
    endtask
endmodule

// ===== verification/wsc_wake_standby_tb_top.sv
/* bench for the wake / standby block: apb tasks and pin model.
   assumes shortened debounce (20/40/60) and long-press (200) counts */
`timescale 1ns/100ps
`include "wsc_regs.vh"
module wsc_wake_standby_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic mode_on, mode_sleep, standby_active, start_sequence, resume_from_sleep;
    logic wake_pin, standby_pin, supply_above_threshold;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int num_errors = 0, checks = 0, n_start = 0, n_resume = 0, cyc = 0, t0, c, k;
    int thr[4] = '{0, 20, 40, 60};
    wsc_wake_standby #(.T_SHORT_CYC(28'h14), .T_MID_CYC(28'h28), .T_LONG_CYC(28'h3C), .T_OFF_CYC(28'hC8)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
        .standby_pin(standby_pin), .supply_above_threshold(supply_above_threshold), .irq(irq),
        .mode_on(mode_on), .mode_sleep(mode_sleep), .standby_active(standby_active),
        .start_sequence(start_sequence), .resume_from_sleep(resume_from_sleep));
    wsc_pin_model pin_u (.pclk(pclk), .wake_pin(wake_pin), .standby_pin(standby_pin),
        .supply_above_threshold(supply_above_threshold));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // cycle count and one-cycle pulses tallied as they pass
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (start_sequence === 1'b1) n_start <= n_start + 1;
        if (resume_from_sleep === 1'b1) n_resume <= n_resume + 1;
    end
    ////////
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no assumed wait count; only the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // wait for the mode output; a hang is left to the watchdog
    task wait_mode(input logic v);
        while (mode_on !== v) @(posedge pclk);
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        $display("wrong value watchdog expected done seen timeout");
        num_errors++;
        wrap_up;
    end
    ////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `WSC_ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h3, rd);
        apb(1'b0, `WSC_ADDR_MASK, 32'h0);
        chk("mask reset", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, `WSC_ADDR_MASK, 32'h1);
        pin_u.bounce(10);
        repeat (30) @(posedge pclk);
        chk("bounce on", 32'h0, mode_on);
        // every debounce code: turn-on delay, then long press to off
        for (c = 0; c < 4; c++) begin
            apb(1'b1, `WSC_ADDR_CTRL, {29'h0, c[1:0], 1'b1});
            pin_u.set_pins(1'b0, 1'b0, 1'b1);
            t0 = cyc;
            wait_mode(1'b1);
            chk("on delay", 32'h1, cyc - t0 >= thr[c] + 3 && cyc - t0 <= thr[c] + 6);
            apb(1'b0, `WSC_ADDR_STATE, 32'h0);
            chk("state on", 32'h8, rd);
            chk("irq", 32'h1, irq);
            wait_mode(1'b0);
            chk("off delay", 32'h1, cyc - t0 >= 203 && cyc - t0 <= 206);
            apb(1'b0, `WSC_ADDR_STATUS, 32'h0);
            chk("flag in off", 32'h0, rd[0]);
            pin_u.set_pins(1'b1, 1'b0, 1'b1);
            repeat (30) @(posedge pclk);
            apb(1'b1, `WSC_ADDR_STATUS, 32'h7);
            apb(1'b0, `WSC_ADDR_STATUS, 32'h0);
            chk("status clear", 32'h0, rd);
            chk("irq clear", 32'h0, irq);
        end
        // long press into sleep, then wake keeps rails
        apb(1'b1, `WSC_ADDR_CTRL, 32'h11);
        pin_u.set_pins(1'b0, 1'b0, 1'b1);
        wait_mode(1'b1);
        wait_mode(1'b0);
        chk("sleep", 32'h1, mode_sleep);
        // sleep keeps the flag, so the rising-edge debounce shows on its own
        apb(1'b1, `WSC_ADDR_STATUS, 32'h7);
        pin_u.set_pins(1'b1, 1'b0, 1'b1);
        repeat (10) @(posedge pclk);
        apb(1'b0, `WSC_ADDR_STATUS, 32'h0);
        chk("rise early", 32'h0, rd);
        repeat (20) @(posedge pclk);
        apb(1'b0, `WSC_ADDR_STATUS, 32'h0);
        chk("rise irq", 32'h1, rd);
        pin_u.set_pins(1'b0, 1'b0, 1'b1);
        wait_mode(1'b1);
        repeat (2) @(posedge pclk);
        chk("resume count", 32'h1, n_resume);
        chk("start count", 32'h5, n_start);
        // level mode: supply gate, on while high, off when low
        apb(1'b1, `WSC_ADDR_CTRL, 32'h10);
        wait_mode(1'b0);
        pin_u.set_pins(1'b1, 1'b0, 1'b0);
        repeat (20) @(posedge pclk);
        chk("on without supply", 32'h0, mode_on);
        pin_u.set_pins(1'b1, 1'b0, 1'b1);
        t0 = cyc;
        wait_mode(1'b1);
        chk("level on", 32'h1, cyc - t0 <= 6);
        apb(1'b1, `WSC_ADDR_CTRL, 32'h0);
        pin_u.set_pins(1'b0, 1'b0, 1'b1);
        wait_mode(1'b0);
        chk("level off", 32'h0, mode_sleep);
        // standby pin under both polarities
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `WSC_ADDR_CTRL, {28'h0, k[1], 3'h0});
            pin_u.set_pins(1'b0, k[0], 1'b1);
            repeat (5) @(posedge pclk);
            chk("standby", {31'h0, k[0] ^ k[1]}, standby_active);
        end
        wrap_up;
    end
endmodule
